// >>> tpc_pkg.sv
// Constants, configuration type and helpers for the TDM port control bank.
// What this block does
// (RQ1) Idle channel outputs the programmable idle byte.
// (RQ2) Underrun without replay outputs the silence byte.
// (RQ3) Idle/silence byte register resets to all ones.
// (RQ4) Idle channel outputs the idle signalling nibble.
// (RQ5) Idle signalling register resets to F000.
// (RQ6) Per-port control at 6200 plus 10 per port.
// (RQ7) Loopback bit routes input through ring buffer.
// (RQ8) Clock switch bit selects internal clock on loss.
// (RQ9) Polarity bit sets which loss input level means loss.
// (RQ10) Software sets polarity bit in structured mode.
// (RQ11) Position bit puts nibble in low or high half.
// (RQ12) DS1 mapping: first 24 slots or three of four.
// (RQ13) Software clears mapping bit in backplane bus mode.
// (RQ14) Software sets internal loss enable with clock switch.
// (RQ15) Bus mode bit selects generic or backplane format.
// (RQ16) Link type bit marks E1 or DS1.
// (RQ17) Mode-specific fields ignored in the other mode.
// (RQ18) Substitution values sampled once per channel slot.
// (RQ19) Reserved bits ignore writes, read as zero.
package tpc_pkg;

  // Register offsets, as seen on the host port.
  localparam logic [15:0] TPC_IDLE_SIL_OFS   = 16'h6000;
  localparam logic [15:0] TPC_IDLE_SIG_OFS   = 16'h6002;
  localparam logic [15:0] TPC_PORT_BASE      = 16'h6200;
  localparam logic [15:0] TPC_PORT_STRIDE    = 16'h0010;

  // Reset values and writable masks.
  localparam logic [15:0] TPC_IDLE_SIL_RST   = 16'hFFFF;
  localparam logic [15:0] TPC_IDLE_SIG_RST   = 16'hF000;
  localparam logic [15:0] TPC_PORT_RST       = 16'h0000;
  localparam logic [15:0] TPC_IDLE_SIG_WMASK = 16'hF000;
  localparam logic [15:0] TPC_PORT_WMASK     = 16'h1FFF;

  // Field positions in the per-port control register.
  localparam int TPC_LPBK_BIT   = 0;
  localparam int TPC_LOSCLK_BIT = 1;
  localparam int TPC_LOSPOL_BIT = 2;
  localparam int TPC_NIBPOS_BIT = 3;
  localparam int TPC_MAP_BIT    = 4;
  localparam int TPC_LINK_BIT   = 9;
  localparam int TPC_INTLOS_BIT = 10;
  localparam int TPC_BUSM_BIT   = 12;

  // Serial framing figures.
  localparam int TPC_NUM_PORTS = 8;
  localparam int TPC_SLOTS     = 32;
  localparam int TPC_DS1_SLOTS = 24;
  localparam int TPC_SLOT_BITS = 8;
  localparam logic [7:0] TPC_UNUSED_BYTE = 8'hFF;
  localparam logic [3:0] TPC_NIB_FILL    = 4'h0;

  // Settings that cross from the host clock to the link clock.
  typedef struct packed {
    logic       structured;
    logic [7:0] idle_byte;
    logic [7:0] silence_byte;
    logic [3:0] idle_nib;
    logic       loopback;
    logic       nib_msb;
    logic       ds1_map;
    logic       ds1_link;
    logic       bus_mode;
  } tpc_cfg_t;

  localparam tpc_cfg_t TPC_CFG_RST = '{
    structured:   1'b0,
    idle_byte:    TPC_IDLE_SIL_RST[7:0],
    silence_byte: TPC_IDLE_SIL_RST[15:8],
    idle_nib:     TPC_IDLE_SIG_RST[15:12],
    loopback:     1'b0,
    nib_msb:      1'b0,
    ds1_map:      1'b0,
    ds1_link:     1'b0,
    bus_mode:     1'b0
  };

  // Places a signalling nibble in the low or high half of a channel byte.
  function automatic logic [7:0] tpc_place_nibble(input logic [3:0] nib,
                                                  input logic msb_side);
    tpc_place_nibble = msb_side ? {nib, TPC_NIB_FILL} : {TPC_NIB_FILL, nib};
  endfunction : tpc_place_nibble

endpackage : tpc_pkg

// >>> tpc_cfg_sync.sv
// Toggle handshake that carries a settings word into the link clock domain.
`timescale 1ns/100ps
module tpc_cfg_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_WORD = '0
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic [W-1:0] src_word,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic      [W-1:0] dst_word
);
  typedef struct packed {
    logic [W-1:0] held;
    logic         req;
    logic         ack1;
    logic         ack2;
  } tpc_src_t;
  typedef struct packed {
    logic [W-1:0] word;
    logic         r1;
    logic         r2;
    logic         r3;
  } tpc_dst_t;

  tpc_src_t s_reg, s_next;
  tpc_dst_t d_reg, d_next;

  // A new word is launched only once the previous one is acknowledged, so
  // the held word is stable whenever the far side samples it.
  always_comb begin
    s_next = s_reg;
    s_next.ack1 = d_reg.r3;
    s_next.ack2 = s_reg.ack1;
    if (s_reg.req == s_reg.ack2 && src_word != s_reg.held) begin
      s_next.held = src_word;
      s_next.req  = ~s_reg.req;
    end
    d_next = d_reg;
    d_next.r1 = s_reg.req;
    d_next.r2 = d_reg.r1;
    d_next.r3 = d_reg.r2;
    if (d_reg.r2 != d_reg.r3) begin
      d_next.word = s_reg.held;
    end
  end

  // Source side registers.
  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      s_reg <= '{held: RST_WORD, req: 1'b0, ack1: 1'b0, ack2: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Destination side registers.
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      d_reg <= '{word: RST_WORD, r1: 1'b0, r2: 1'b0, r3: 1'b0};
    end else begin
      d_reg <= d_next;
    end
  end

  assign dst_word = d_reg.word;

endmodule : tpc_cfg_sync

// >>> tpc_loop_mem.sv
// Small ring buffer memory with registered read data for slot loopback.
`timescale 1ns/100ps
module tpc_loop_mem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0]              rd;
  } tpc_mem_t;

  tpc_mem_t m_reg, m_next;

  // Read returns the old content when both ports hit one address.
  always_comb begin
    m_next = m_reg;
    m_next.rd = m_reg.mem[raddr];
    if (we) begin
      m_next.mem[waddr] = wdata;
    end
  end

  // Contents need no reset; a buffer is refilled within one frame.
  always_ff @(posedge clk) begin
    m_reg <= m_next;
  end

  assign rdata = m_reg.rd;

endmodule : tpc_loop_mem

// >>> tpc_port_ctrl.sv
// TDM port control registers and serial output substitution for one link.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module tpc_port_ctrl #(
  parameter int NUM_PORTS = tpc_pkg::TPC_NUM_PORTS,
  parameter int LINK_PORT = 0,
  parameter int SLOTS     = tpc_pkg::TPC_SLOTS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rdata,
  input  wire logic        structured_mode,
  output logic             internal_clock_select,
  output logic             internal_loss_event,
  input  wire logic        line_clock_in,
  input  wire logic        frame_pulse_in,
  input  wire logic        serial_data_in,
  input  wire logic        signalling_or_loss_in,
  input  wire logic [7:0]  reasm_byte,
  input  wire logic [3:0]  reasm_nibble,
  input  wire logic        chan_idle,
  input  wire logic        chan_underrun,
  input  wire logic        underrun_replay_select,
  input  wire logic [7:0]  replay_byte,
  output logic             serial_data_out,
  output logic             signalling_out
);
  import tpc_pkg::*;

  localparam int SW = $clog2(SLOTS);
  localparam logic [SW-1:0] LAST_SLOT = SW'(SLOTS - 1);
  localparam logic [2:0] LAST_BIT = 3'(TPC_SLOT_BITS - 1);

  typedef struct packed {
    logic [15:0]                  idle_sil;
    logic [15:0]                  idle_sig;
    logic [NUM_PORTS-1:0][15:0]   port;
    logic [15:0]                  rd;
    logic                         los1;
    logic                         los2;
    logic                         clk_sel;
    logic                         loss_prop;
  } tpc_core_t;

  typedef struct packed {
    logic          rs1;
    logic          rs2;
    logic          fp1;
    logic          fp2;
    logic          fp3;
    logic          di1;
    logic          di2;
    logic [2:0]    bit_cnt;
    logic [SW-1:0] slot;
    logic [7:0]    shin;
    logic [7:0]    shout;
    logic [7:0]    sigout;
  } tpc_link_t;

  tpc_core_t c_reg, c_next;
  tpc_link_t l_reg, l_next;
  tpc_cfg_t  cfg_src, cfg;
  logic      [8:0] wr_dec, rd_dec;
  logic      [15:0] lp;
  logic      loss;
  logic      [SW-1:0] nslot;
  logic      slot_used;
  logic      load;
  logic      [7:0] next_byte;
  logic      [7:0] next_sig;
  logic      [7:0] mem_rdata;

  // Returns a hit flag and the port index for a per-port register address.
  function automatic logic [8:0] port_decode(input logic [15:0] a);
    logic [15:0] off;
    off = a - TPC_PORT_BASE;
    port_decode = {a >= TPC_PORT_BASE && off[3:0] == 4'h0 &&
                   off < 16'(NUM_PORTS) * TPC_PORT_STRIDE, off[11:4]};
  endfunction : port_decode

  assign wr_dec = port_decode(addr);
  assign rd_dec = port_decode(addr);
  assign lp     = c_reg.port[LINK_PORT];

  // Level on the shared pin that counts as loss depends on the polarity.
  // The pin is resampled on the host clock, so loss shows two cycles late.
  assign loss = (c_reg.los2 == lp[TPC_LOSPOL_BIT]); // RQ9

  // Host side: register writes, one-cycle read data, loss handling.
  always_comb begin
    c_next = c_reg;
    c_next.rd   = 16'h0000;
    c_next.los1 = signalling_or_loss_in;
    c_next.los2 = c_reg.los1;
    if (wr_stb) begin
      if (addr == TPC_IDLE_SIL_OFS) begin
        c_next.idle_sil = wdata;
      end else if (addr == TPC_IDLE_SIG_OFS) begin
        c_next.idle_sig = wdata & TPC_IDLE_SIG_WMASK; // RQ19
      end else if (wr_dec[8]) begin
        c_next.port[wr_dec[7:0]] = wdata & TPC_PORT_WMASK; // RQ6 RQ19
      end
    end
    if (rd_stb) begin
      if (addr == TPC_IDLE_SIL_OFS) begin
        c_next.rd = c_reg.idle_sil;
      end else if (addr == TPC_IDLE_SIG_OFS) begin
        c_next.rd = c_reg.idle_sig;
      end else if (rd_dec[8]) begin
        c_next.rd = c_reg.port[rd_dec[7:0]];
      end
    end
    // Loss handling only acts in unstructured mode.
    c_next.clk_sel   = !structured_mode && lp[TPC_LOSCLK_BIT] && loss; // RQ8 RQ17
    c_next.loss_prop = !structured_mode && lp[TPC_INTLOS_BIT] && loss;
  end

  // Host clock registers; the clock enable freezes these, but not the settings handshake, which also runs on clk.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c_reg.idle_sil  <= TPC_IDLE_SIL_RST; // RQ3
      c_reg.idle_sig  <= TPC_IDLE_SIG_RST; // RQ5
      c_reg.port      <= {NUM_PORTS{TPC_PORT_RST}}; // RQ6
      c_reg.rd        <= 16'h0000;
      c_reg.los1      <= 1'b0;
      c_reg.los2      <= 1'b0;
      c_reg.clk_sel   <= 1'b0;
      c_reg.loss_prop <= 1'b0;
    end else if (ce) begin
      c_reg <= c_next;
    end
  end

  assign rdata                 = c_reg.rd;
  assign internal_clock_select = c_reg.clk_sel;
  assign internal_loss_event   = c_reg.loss_prop;

  // Settings word handed to the link side.
  assign cfg_src = '{
    structured:   structured_mode,
    idle_byte:    c_reg.idle_sil[7:0],
    silence_byte: c_reg.idle_sil[15:8],
    idle_nib:     c_reg.idle_sig[15:12],
    loopback:     lp[TPC_LPBK_BIT],
    nib_msb:      lp[TPC_NIBPOS_BIT],
    ds1_map:      lp[TPC_MAP_BIT],
    ds1_link:     lp[TPC_LINK_BIT],
    bus_mode:     lp[TPC_BUSM_BIT]
  };

  // The handshake costs a few clocks of latency but never delivers a torn
  // word; settings change rarely, so the delay is of no consequence.
  tpc_cfg_sync #(
    .W        ($bits(tpc_cfg_t)),
    .RST_WORD (TPC_CFG_RST)
  ) u_cfg_sync (
    .src_clk   (clk),
    .src_rst_n (rst_n),
    .src_word  (cfg_src),
    .dst_clk   (line_clock_in),
    .dst_rst_n (l_reg.rs2),
    .dst_word  (cfg)
  );

  // Slot ring buffer: each input byte comes back one frame later.
  tpc_loop_mem #(
    .AW (SW),
    .DW (8)
  ) u_loop_mem (
    .clk   (line_clock_in),
    .we    (l_reg.rs2 && l_reg.bit_cnt == LAST_BIT),
    .waddr (l_reg.slot),
    .wdata ({l_reg.shin[6:0], l_reg.di2}),
    .raddr (nslot),
    .rdata (mem_rdata)
  );

  // Load fires on the last bit of a slot, when the next slot's byte enters.
  assign nslot = (l_reg.slot == LAST_SLOT) ? '0 : l_reg.slot + 1'b1;
  assign load  = l_reg.rs2 && l_reg.bit_cnt == LAST_BIT;

  // DS1 slot mapping applies to a DS1 link on the generic bus only.
  always_comb begin
    slot_used = 1'b1;
    if (cfg.structured && cfg.ds1_link && !cfg.bus_mode) begin // RQ15 RQ16
      slot_used = cfg.ds1_map ? (nslot[1:0] != 2'b00)
                              : (nslot < SW'(TPC_DS1_SLOTS)); // RQ12
    end
  end

  // Byte for the coming slot; substitution only happens in structured mode.
  always_comb begin
    next_byte = reasm_byte;
    next_sig  = tpc_place_nibble(reasm_nibble, cfg.nib_msb); // RQ11
    if (cfg.structured) begin // RQ17
      if (cfg.loopback) begin
        next_byte = mem_rdata; // RQ7
      end else if (!slot_used) begin
        next_byte = TPC_UNUSED_BYTE;
      end else if (chan_idle) begin
        next_byte = cfg.idle_byte; // RQ1
      end else if (chan_underrun) begin
        next_byte = underrun_replay_select ? replay_byte
                                           : cfg.silence_byte; // RQ2
      end
      if (chan_idle) begin
        next_sig = tpc_place_nibble(cfg.idle_nib, cfg.nib_msb); // RQ4
      end
    end else begin
      next_sig = TPC_UNUSED_BYTE;
    end
  end

  // Link side: framing counters and shift registers on the line clock.
  always_comb begin
    l_next = l_reg;
    l_next.rs1 = rst_n;
    l_next.rs2 = l_reg.rs1;
    l_next.fp1 = frame_pulse_in;
    l_next.fp2 = l_reg.fp1;
    l_next.fp3 = l_reg.fp2;
    l_next.di1 = serial_data_in;
    l_next.di2 = l_reg.di1;
    if (!l_reg.rs2) begin
      l_next.bit_cnt = 3'h0;
      l_next.slot    = '0;
      l_next.shin    = 8'h00;
      l_next.shout   = TPC_UNUSED_BYTE;
      l_next.sigout  = TPC_UNUSED_BYTE;
    end else begin
      l_next.shin    = {l_reg.shin[6:0], l_reg.di2};
      l_next.shout   = {l_reg.shout[6:0], 1'b1};
      l_next.sigout  = {l_reg.sigout[6:0], 1'b1};
      l_next.bit_cnt = l_reg.bit_cnt + 3'h1;
      if (load) begin
        // Values are taken once per slot, so a change lands at a slot edge.
        l_next.slot   = nslot;
        l_next.shout  = next_byte; // RQ18
        l_next.sigout = next_sig;
      end
      if (l_reg.fp2 && !l_reg.fp3) begin
        // The pulse's own first bit is shifted in at this edge, so the
        // count restarts at one and input bytes stay whole.
        l_next.bit_cnt = 3'h1;
        l_next.slot    = '0;
      end
    end
  end

  // The link clock must keep running; the reset synchroniser and the settings handshake both need it.
  always_ff @(posedge line_clock_in) begin
    l_reg <= l_next;
  end

  // Both outputs come straight from the top bits of their shift registers.
  assign serial_data_out = l_reg.shout[7];
  assign signalling_out  = l_reg.sigout[7];

  // Checks on the host side.
  byte_reset_a: assert property (@(posedge clk) // RQ3
    $rose(rst_n) |-> c_reg.idle_sil == TPC_IDLE_SIL_RST)
    else $error("Idle and silence bytes not all ones after reset.");
  sig_reset_a: assert property (@(posedge clk) // RQ5
    $rose(rst_n) |-> c_reg.idle_sig == TPC_IDLE_SIG_RST && rdata == 16'h0000)
    else $error("Idle signalling register has wrong reset value.");
  port_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
    ce && wr_stb && addr == TPC_PORT_BASE + TPC_PORT_STRIDE ##1
    ce && rd_stb && addr == TPC_PORT_BASE + TPC_PORT_STRIDE && ce
    |=> rdata == ($past(wdata, 2) & TPC_PORT_WMASK))
    else $error("Port register did not read back its write.");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ19
    ce && rd_stb && addr == TPC_IDLE_SIG_OFS |=> rdata[11:0] == 12'h000)
    else $error("Reserved signalling bits read nonzero.");
  clock_switch_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    $past(ce) && internal_clock_select |->
    !$past(structured_mode) && $past(lp[TPC_LOSCLK_BIT]))
    else $error("Clock switched without unstructured mode and switch bit.");
  loss_polarity_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    $past(ce) && internal_loss_event |->
    $past(c_reg.los2) == $past(lp[TPC_LOSPOL_BIT]))
    else $error("Loss reported with the pin at its normal level.");

  // Checks on the link side.
  idle_output_a: assert property (@(posedge line_clock_in) // RQ1
    disable iff (!l_reg.rs2)
    load && cfg.structured && !cfg.loopback && slot_used && chan_idle
    |=> l_reg.shout == $past(cfg.idle_byte))
    else $error("Idle channel did not carry the idle byte.");
  silence_output_a: assert property (@(posedge line_clock_in) // RQ2
    disable iff (!l_reg.rs2)
    load && cfg.structured && !cfg.loopback && slot_used && !chan_idle &&
    chan_underrun && !underrun_replay_select
    |=> l_reg.shout == $past(cfg.silence_byte))
    else $error("Underrun channel did not carry the silence byte.");
  nibble_place_a: assert property (@(posedge line_clock_in) // RQ11
    disable iff (!l_reg.rs2)
    load && cfg.structured && chan_idle && cfg.nib_msb
    |=> l_reg.sigout[7:4] == $past(cfg.idle_nib))
    else $error("Idle nibble not in the high half.");
  ds1_map_a: assert property (@(posedge line_clock_in) // RQ12
    disable iff (!l_reg.rs2)
    load && cfg.structured && cfg.ds1_link && !cfg.bus_mode &&
    !cfg.loopback && !cfg.ds1_map && nslot >= SW'(TPC_DS1_SLOTS)
    |=> l_reg.shout == TPC_UNUSED_BYTE)
    else $error("Slot beyond the DS1 range was mapped.");
  unstructured_pass_a: assert property (@(posedge line_clock_in) // RQ17
    disable iff (!l_reg.rs2)
    load && !cfg.structured |=> l_reg.shout == $past(reasm_byte))
    else $error("Unstructured mode altered the data byte.");
  loopback_output_a: assert property (@(posedge line_clock_in) // RQ7
    disable iff (!l_reg.rs2)
    load && cfg.structured && cfg.loopback
    |=> l_reg.shout == $past(mem_rdata))
    else $error("Loopback slot did not carry the buffered byte.");
  three_of_four_a: assert property (@(posedge line_clock_in) // RQ12
    disable iff (!l_reg.rs2)
    load && cfg.structured && cfg.ds1_link && !cfg.bus_mode &&
    !cfg.loopback && cfg.ds1_map && nslot[1:0] == 2'b00
    |=> l_reg.shout == TPC_UNUSED_BYTE)
    else $error("Fourth slot of a DS1 group was mapped.");
  backplane_all_a: assert property (@(posedge line_clock_in) // RQ15
    disable iff (!l_reg.rs2)
    load && cfg.structured && cfg.bus_mode && !cfg.loopback &&
    !chan_idle && !chan_underrun |=> l_reg.shout == $past(reasm_byte))
    else $error("Backplane bus mode left a slot unmapped.");
  unstructured_sig_a: assert property (@(posedge line_clock_in) // RQ17
    disable iff (!l_reg.rs2)
    load && !cfg.structured |=> l_reg.sigout == TPC_UNUSED_BYTE)
    else $error("Unstructured mode drove signalling nibbles.");
  nibble_low_a: assert property (@(posedge line_clock_in) // RQ4
    disable iff (!l_reg.rs2)
    load && cfg.structured && chan_idle && !cfg.nib_msb
    |=> l_reg.sigout == {TPC_NIB_FILL, $past(cfg.idle_nib)})
    else $error("Idle nibble not in the low half.");

  // Covers for the main scenarios.
  idle_seen_c: cover property (@(posedge line_clock_in)
    load && cfg.structured && chan_idle);
  silence_seen_c: cover property (@(posedge line_clock_in)
    load && cfg.structured && chan_underrun && !underrun_replay_select);
  loopback_seen_c: cover property (@(posedge line_clock_in)
    load && cfg.structured && cfg.loopback);
  switch_seen_c: cover property (@(posedge clk) $rose(internal_clock_select));
  ds1_seen_c: cover property (@(posedge line_clock_in)
    load && cfg.structured && cfg.ds1_link && !slot_used);

endmodule : tpc_port_ctrl

// >>> tpc_link_model.sv
// Framer-side model: line clock, frame pulse, serial input, output capture.
`timescale 1ns/100ps
module tpc_link_model #(
  parameter logic [7:0] IN_BYTE = 8'h00
) (
  output logic       line_clock_in,
  output logic       frame_pulse_in,
  output logic       serial_data_in,
  output logic       signalling_or_loss_in,
  input  wire logic  loss_level,
  input  wire logic  serial_data_out,
  input  wire logic  signalling_out,
  output logic [7:0] data_win,
  output logic [7:0] sig_win,
  output logic [2:0] bit_pos
);
  logic [7:0] cnt = 8'h00;

  // The line clock runs free, as a framer's clock does between frames.
  initial begin
    line_clock_in = 1'b0;
    #13;
    forever #32 line_clock_in = ~line_clock_in;
  end

  // Outputs move on the falling edge so the device samples settled levels.
  always @(negedge line_clock_in) begin
    cnt <= cnt + 8'h01;
  end

  // One frame pulse per 256 bit times; input byte sent MSB first.
  assign frame_pulse_in        = (cnt == 8'h00);
  assign serial_data_in        = IN_BYTE[3'd7 - cnt[2:0]];
  assign signalling_or_loss_in = loss_level;
  assign bit_pos               = cnt[2:0];

  // Capture the last eight bits of each output, as the framer receives them.
  always @(posedge line_clock_in) begin
    data_win <= {data_win[6:0], serial_data_out};
    sig_win  <= {sig_win[6:0], signalling_out};
  end
endmodule : tpc_link_model

// >>> tpc_port_ctrl_tb.sv
// Self-checking bench for the TDM port control bank and its link output.
`timescale 1ns/100ps
module tpc_port_ctrl_tb;
  import tpc_pkg::*;
  logic        clk             = 1'b0;
  logic        rst_n           = 1'b0;
  logic        ce              = 1'b1;
  logic [15:0] addr            = 16'h0000;
  logic [15:0] wdata           = 16'h0000;
  logic        wr_stb          = 1'b0;
  logic        rd_stb          = 1'b0;
  logic        structured_mode = 1'b0;
  logic        chan_idle       = 1'b0;
  logic        chan_underrun   = 1'b0;
  logic        replay_sel      = 1'b0;
  logic        loss_level      = 1'b1;
  logic [15:0] rdata;
  logic        ics, ile, lclk, fp, sdi, sloss, sdo, so;
  logic [7:0]  dwin, swin;
  logic [2:0]  bpos;
  logic [2:0]  ph;
  int          mismatches = 0;
  int          checks     = 0;

  always #5 clk = ~clk;

  tpc_port_ctrl dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .structured_mode(structured_mode), .internal_clock_select(ics),
    .internal_loss_event(ile), .line_clock_in(lclk), .frame_pulse_in(fp),
    .serial_data_in(sdi), .signalling_or_loss_in(sloss),
    .reasm_byte(8'h3C), .reasm_nibble(4'h6), .chan_idle(chan_idle),
    .chan_underrun(chan_underrun), .underrun_replay_select(replay_sel),
    .replay_byte(8'h81), .serial_data_out(sdo), .signalling_out(so));

  tpc_link_model #(.IN_BYTE(8'h96)) link (.line_clock_in(lclk),
    .frame_pulse_in(fp),
    .serial_data_in(sdi), .signalling_or_loss_in(sloss),
    .loss_level(loss_level), .serial_data_out(sdo), .signalling_out(so),
    .data_win(dwin), .sig_win(swin), .bit_pos(bpos));

  // Compare and count; a mismatch is reported at once.
  task automatic chk(input string n, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // Host writes and reads; read data stand only in the following cycle.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp,
                    input string n);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(n, rdata, exp);
  endtask : rd

  // Write and read back with no idle cycle between the two strobes.
  task automatic wrrd(input logic [15:0] a, input logic [15:0] d,
                      input logic [15:0] exp, input string n);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(n, rdata, exp);
  endtask : wrrd

  // Loss flags pass a synchroniser, so allow a bounded wait.
  task automatic flags(input logic [1:0] exp, input string n);
    int i;
    for (i = 0; i < 40 && {ics, ile} !== exp; i++) @(posedge clk);
    chk(n, {14'h0000, ics, ile}, {14'h0000, exp});
  endtask : flags

  // Settings cross domains and the ring buffer needs a whole frame.
  task automatic settle;
    repeat (300) @(posedge lclk);
  endtask : settle

  task automatic slot(input logic [7:0] ed, input logic [7:0] es,
                      input string n);
    do @(posedge lclk); while (bpos !== ph);
    #1;
    chk(n, {8'h00, dwin}, {8'h00, ed});
    chk(n, {8'h00, swin}, {8'h00, es});
  endtask : slot

  // Counts unused-slot bytes in one frame and whether any two are adjacent.
  task automatic ffcount(input int en, input logic ep, input string n);
    int   c;
    logic pair;
    logic last;
    c    = 0;
    pair = 1'b0;
    last = 1'b0;
    settle;
    repeat (32) begin
      do @(posedge lclk); while (bpos !== ph);
      #1;
      if (dwin === 8'hFF) begin
        c++;
        pair = pair | last;
      end
      last = (dwin === 8'hFF);
    end
    chk(n, 16'(c), 16'(en));
    chk(n, {15'h0000, pair}, {15'h0000, ep});
  endtask : ffcount

  initial begin
    // Held longer than three cycles so the link side sees its reset too.
    repeat (30) @(posedge clk);
    rst_n <= 1'b1;
    rd(16'h6000, 16'hFFFF, "idle_sil_rst");
    rd(16'h6002, 16'hF000, "idle_sig_rst");
    rd(16'h6200, 16'h0000, "port0_rst");
    rd(16'h6210, 16'h0000, "port1_rst");
    wr(16'h6002, 16'h9FFF);
    rd(16'h6002, 16'h9000, "idle_sig_mask");
    wr(16'h6200, 16'hFFFF);
    rd(16'h6200, 16'h1FFF, "port0_mask");
    wrrd(16'h6210, 16'hE215, 16'h0215, "port1_data");
    rd(16'h6200, 16'h1FFF, "port0_keep");
    wr(16'h6004, 16'h1234);
    rd(16'h6004, 16'h0000, "unmapped");
    @(posedge clk);
    ce <= 1'b0;
    wr(16'h6000, 16'hC3A5);
    @(posedge clk);
    ce <= 1'b1;
    rd(16'h6000, 16'hFFFF, "ce_low");
    wr(16'h6000, 16'hC3A5);
    rd(16'h6000, 16'hC3A5, "idle_sil_data");
    // Structured idle channel; the byte's phase in the stream is learned.
    @(posedge clk);
    structured_mode <= 1'b1;
    chan_idle       <= 1'b1;
    wr(16'h6200, 16'h0004);
    settle;
    ph = 3'd0;
    repeat (8) begin
      @(posedge lclk);
      #1;
      if (dwin === 8'hA5) ph = bpos;
    end
    slot(8'hA5, 8'h09, "idle_low");
    wr(16'h6200, 16'h000C);
    settle;
    slot(8'hA5, 8'h90, "idle_high");
    wr(16'h6000, 16'hC35A);
    @(posedge clk);
    chan_underrun <= 1'b1;
    settle;
    slot(8'h5A, 8'h90, "idle_update");
    @(posedge clk);
    chan_idle <= 1'b0;
    settle;
    slot(8'hC3, 8'h60, "silence");
    @(posedge clk);
    replay_sel <= 1'b1;
    settle;
    slot(8'h81, 8'h60, "replay");
    @(posedge clk);
    chan_underrun <= 1'b0;
    wr(16'h6200, 16'h0005);
    settle;
    slot(8'h96, 8'h06, "loopback");
    wr(16'h6200, 16'h0004);
    settle;
    slot(8'h3C, 8'h06, "normal");
    wr(16'h6200, 16'h0204);
    ffcount(8, 1'b1, "ds1_first24");
    wr(16'h6200, 16'h0214);
    ffcount(8, 1'b0, "ds1_three_of_four");
    wr(16'h6200, 16'h0014);
    ffcount(0, 1'b0, "e1_all");
    wr(16'h6200, 16'h1204);
    ffcount(0, 1'b0, "backplane_all");
    // Unstructured: structured-only fields must do nothing.
    @(posedge clk);
    structured_mode <= 1'b0;
    chan_idle       <= 1'b1;
    wr(16'h6200, 16'h000D);
    settle;
    slot(8'h3C, 8'hFF, "unstructured");
    @(posedge clk);
    loss_level <= 1'b0;
    wr(16'h6200, 16'h0402);
    flags(2'b11, "loss_low_pol");
    @(posedge clk);
    loss_level <= 1'b1;
    flags(2'b00, "no_loss_low_pol");
    wr(16'h6200, 16'h0406);
    flags(2'b11, "loss_high_pol");
    wr(16'h6200, 16'h0404);
    flags(2'b01, "no_clock_switch");
    @(posedge clk);
    structured_mode <= 1'b1;
    wr(16'h6200, 16'h0406);
    flags(2'b00, "loss_in_structured");
    finish_test;
  end

  // The run needs roughly 30,000 host cycles; cut off a hang well after.
  initial begin
    #800000;
    mismatches++;
    finish_test;
  end
endmodule : tpc_port_ctrl_tb
